// ==== hdl/efx_pkg.sv ====
package efx_pkg;
  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] GCTRL_OFS     = 8'h00;
  localparam logic [7:0] GFSR_NS_OFS   = 8'h04;
  localparam logic [7:0] GFSR_S_OFS    = 8'h08;
  localparam logic [7:0] GFAR_OFS      = 8'h0c;
  localparam logic [7:0] GSYN_OFS      = 8'h10;
  localparam logic [7:0] CTX_BASE      = 8'h40;
  localparam int         CTX_STRIDE_LG = 5;
  // Offsets inside one context bank window
  localparam logic [4:0] CMD_UR_OFS    = 5'h00;
  localparam logic [4:0] CMD_UW_OFS    = 5'h04;
  localparam logic [4:0] CMD_PR_OFS    = 5'h08;
  localparam logic [4:0] CMD_PW_OFS    = 5'h0c;
  localparam logic [4:0] RESULT_OFS    = 5'h10;
  localparam logic [4:0] PROGRESS_OFS  = 5'h14;
  localparam logic [4:0] CFSR_OFS      = 5'h18;
  localparam logic [4:0] CCFG_OFS      = 5'h1c;
  localparam logic [4:0] CFAR_OFS      = 5'h08;
  localparam logic [4:0] CSYN_OFS      = 5'h0c;
  // ==========================================================
  // Fields and codes
  // ==========================================================
  localparam int GCTRL_REPORT_BIT   = 0;
  localparam int GCTRL_OVERRIDE_BIT = 1;
  localparam int GCTRL_ASYNC_GLB    = 2;
  localparam int CCFG_REPORT_BIT    = 0;
  localparam int CCFG_TERM_BIT      = 1;
  localparam int CCFG_S2_LSB        = 4;
  localparam int FSR_EXT_BIT        = 0;
  localparam int FSR_MULTI_BIT      = 31;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [6:0] OP_TERMINATED_CODE = 7'h7f;
  localparam logic [6:0] OP_EXT_ABORT_CODE  = 7'h10;

  typedef enum logic [1:0] {
    EFX_RESP_OKAY   = 2'b00,
    EFX_RESP_EXFAIL = 2'b01,
    EFX_RESP_ABORT  = 2'b10
  } efx_resp_code_t;

  typedef enum logic [1:0] {
    EFX_IDLE  = 2'b00,
    EFX_ISSUE = 2'b01,
    EFX_WAIT  = 2'b10,
    EFX_DONE  = 2'b11
  } efx_state_t;

  typedef struct packed {
    logic        valid;
    logic        sync;
    logic        bypass;
    logic        nested;
    logic        secure;
    logic        exclusive;
    logic [3:0]  ctx;
    logic [3:0]  s2_ctx;
    logic [31:0] addr;
    logic [31:0] syndrome;
  } efx_abort_t;

  typedef struct packed {
    logic           valid;
    efx_resp_code_t code;
  } efx_resp_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  ctx;
    logic [1:0]  kind;
    logic [31:0] addr;
  } efx_walk_req_t;

  typedef struct packed {
    logic        valid;
    logic        ok;
    logic        ext_abort;
    logic        stage2;
    logic [6:0]  code;
    logic [31:0] out_addr;
  } efx_walk_rsp_t;
endpackage : efx_pkg

// ==== hdl/efx_ram.sv ====
// ==========================================================
// Small per-bank store with registered read
// ==========================================================
module efx_ram #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  // Clock
  input  wire logic                     sys_clk_i,
  // Write port
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic      [WIDTH-1:0]         rd_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2) begin : g_depth_check
    $error("efx_ram needs DEPTH of two or more");
  end

  // No reset: contents count as unknown until first capture
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) mem[wr_addr_i] <= wr_data_i;
    rd_data_o <= mem[rd_addr_i];
  end
endmodule : efx_ram

// ==== hdl/efx_gfault.sv ====
// ==========================================================
// One banked global fault status register
// ==========================================================
module efx_gfault
  import efx_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // Fault event and software clear
  input  wire logic        fault_i,
  input  wire logic [31:0] clr_mask_i,
  // State
  output logic      [31:0] status_o,
  output logic             first_o
);
  logic [31:0] status_d;
  logic [31:0] status_q;
  logic        busy;

  // Only a fault into an empty register carries details
  assign busy     = |status_q;
  assign first_o  = fault_i & ~busy;
  assign status_d = (status_q & ~clr_mask_i)
                  | (first_o ? 32'h1 << FSR_EXT_BIT : 32'h0)
                  | (fault_i & busy ? 32'h1 << FSR_MULTI_BIT : 32'h0);
  assign status_o = status_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) status_q <= RESET_WORD;
    else            status_q <= status_d;
  end
endmodule : efx_gfault

// ==== hdl/efx_top.sv ====
// Implementation choices: the address map and the address-and-strobe port.
module efx_top
  import efx_pkg::*;
#(
  parameter int NUM_CTX = 4
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          reset_n_i,
  // Register port
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [31:0]   reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [31:0]   reg_rdata_o,
  // External aborts from the interconnect
  input  wire efx_abort_t    abort_i,
  output efx_resp_t          abort_resp_o,
  // Table walker
  output efx_walk_req_t      walk_req_o,
  input  wire efx_walk_rsp_t walk_rsp_i
);
  localparam int IW = $clog2(NUM_CTX);

  if (NUM_CTX < 2 || NUM_CTX > 4) begin : g_num_ctx_check
    $error("efx_top supports 2 to 4 context banks: capture page holds four");
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  // Lowest pending bank wins; fixed priority is fine since each
  // bank has at most one command outstanding
  function automatic logic [IW-1:0] first_one(input logic [NUM_CTX-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = NUM_CTX - 1; i >= 0; i--) begin
      if (v[i]) r = IW'(i);
    end
    return r;
  endfunction : first_one

  // Status update: clear first so a new fault always survives
  function automatic logic [31:0] fsr_next(input logic [31:0] cur, input logic set,
                                           input logic [31:0] clr);
    logic [31:0] r;
    r = cur & ~clr;
    if (set && cur == 32'h0) r = r | (32'h1 << FSR_EXT_BIT);
    if (set && cur != 32'h0) r = r | (32'h1 << FSR_MULTI_BIT);
    return r;
  endfunction : fsr_next

  // ==========================================================
  // State
  // ==========================================================
  logic [2:0]          gctrl_q;
  logic [31:0]         gfar_q;
  logic [31:0]         gsyn_q;
  logic [31:0]         fsr_q    [NUM_CTX];
  logic [31:0]         result_q [NUM_CTX];
  logic [7:0]          ccfg_q   [NUM_CTX];
  logic [31:0]         opaddr_q [NUM_CTX];
  logic [1:0]          opkind_q [NUM_CTX];
  logic [NUM_CTX-1:0]  active_q;
  logic [NUM_CTX-1:0]  pend_q;
  efx_state_t          state_q;
  logic [IW-1:0]       sel_q;
  logic [31:0]         rdata_q;
  logic                ram_rd_q;
  logic                ram_hi_q;
  efx_resp_t           resp_q;
  efx_walk_req_t       walk_q;

  // ==========================================================
  // Register decode
  // ==========================================================
  logic          ctx_hit;
  logic [IW-1:0] ctx_idx;
  logic [4:0]    ctx_ofs;
  logic [2:0]    ctx_page;
  logic          far_page;
  logic          cmd_wr;
  logic          ns_clr_hit;
  logic          s_clr_hit;

  // Banks sit at 32-byte pages from CTX_BASE; the page after the
  // last bank holds the captured fault address and syndrome
  assign ctx_page   = 3'(reg_addr_i[7:CTX_STRIDE_LG] - CTX_BASE[7:CTX_STRIDE_LG]);
  assign ctx_hit    = reg_addr_i >= CTX_BASE && ctx_page < 3'(NUM_CTX);
  assign far_page   = reg_addr_i >= CTX_BASE && ctx_page == 3'(NUM_CTX);
  assign ctx_idx    = far_page ? reg_addr_i[IW+2:3] : IW'(ctx_page);
  assign ctx_ofs    = reg_addr_i[4:0];
  assign cmd_wr     = reg_wr_i & ctx_hit & (ctx_ofs < RESULT_OFS);
  assign ns_clr_hit = reg_wr_i & (reg_addr_i == GFSR_NS_OFS);
  assign s_clr_hit  = reg_wr_i & (reg_addr_i == GFSR_S_OFS);

  // ==========================================================
  // External abort routing
  // ==========================================================
  logic          ab_global;
  logic          ab_glob_sec;
  logic [IW-1:0] ab_ctx;
  logic          ns_set;
  logic          s_set;
  logic          ns_first;
  logic          s_first;
  logic          ab_report;
  logic [31:0]   gfsr_ns;
  logic [31:0]   gfsr_s;

  // Bypassed traffic, or async aborts when steered global
  assign ab_global = abort_i.bypass
                   | (~abort_i.sync & gctrl_q[GCTRL_ASYNC_GLB]);
  // Nested traffic records in the stage 2 bank
  assign ab_ctx    = abort_i.nested ? abort_i.s2_ctx[IW-1:0]
                                    : abort_i.ctx[IW-1:0];
  // Async global faults bank by override, sync ones by security
  assign ab_glob_sec = abort_i.sync ? abort_i.secure
                                    : gctrl_q[GCTRL_OVERRIDE_BIT];
  assign ns_set    = abort_i.valid & ab_global & ~ab_glob_sec;
  assign s_set     = abort_i.valid & ab_global & ab_glob_sec;
  assign ab_report = ab_global ? gctrl_q[GCTRL_REPORT_BIT]
                               : ccfg_q[ab_ctx][CCFG_REPORT_BIT];

  efx_gfault u_gfsr_ns (
    .sys_clk_i  (sys_clk_i),
    .reset_n_i  (reset_n_i),
    .fault_i    (ns_set),
    .clr_mask_i (ns_clr_hit ? reg_wdata_i : 32'h0),
    .status_o   (gfsr_ns),
    .first_o    (ns_first)
  );

  efx_gfault u_gfsr_s (
    .sys_clk_i  (sys_clk_i),
    .reset_n_i  (reset_n_i),
    .fault_i    (s_set),
    .clr_mask_i (s_clr_hit ? reg_wdata_i : 32'h0),
    .status_o   (gfsr_s),
    .first_o    (s_first)
  );

  // ==========================================================
  // Context fault status and capture store
  // ==========================================================
  logic               op_s2_fault;
  logic [IW-1:0]      op_s2_ctx;
  logic [NUM_CTX-1:0] ctx_set;
  logic               ram_wr;
  logic [63:0]        ram_rd;

  // Stage 2 walk abort during a command marks the stage 2 bank
  assign op_s2_fault = (state_q == EFX_WAIT) & walk_rsp_i.valid & ~walk_rsp_i.ok
                     & walk_rsp_i.stage2;
  assign op_s2_ctx   = ccfg_q[sel_q][CCFG_S2_LSB +: IW];
  // Details only for a sync abort landing in an empty register
  assign ram_wr      = abort_i.valid & abort_i.sync & ~ab_global
                     & (fsr_q[ab_ctx] == 32'h0);

  always_comb begin
    for (int i = 0; i < NUM_CTX; i++) begin
      ctx_set[i] = (abort_i.valid & ~ab_global & (ab_ctx == IW'(i)))
                 | (op_s2_fault & (op_s2_ctx == IW'(i)));
    end
  end

  efx_ram #(
    .WIDTH (64),
    .DEPTH (NUM_CTX)
  ) u_capture (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (ram_wr),
    .wr_addr_i (ab_ctx),
    .wr_data_i ({abort_i.addr, abort_i.syndrome}),
    .rd_addr_i (ctx_idx),
    .rd_data_o (ram_rd)
  );

  // Set beats a same-cycle software clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_CTX; i++) fsr_q[i] <= RESET_WORD;
    end else begin
      for (int i = 0; i < NUM_CTX; i++) begin
        fsr_q[i] <= fsr_next(fsr_q[i], ctx_set[i],
                             (reg_wr_i && ctx_hit && ctx_idx == IW'(i) && ctx_ofs == CFSR_OFS)
                             ? reg_wdata_i : 32'h0);
      end
    end
  end

  // Global capture; async aborts leave it untouched
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gfar_q <= RESET_WORD;
      gsyn_q <= RESET_WORD;
    end else if (abort_i.sync && (ns_first || s_first)) begin
      gfar_q <= abort_i.addr;
      gsyn_q <= abort_i.syndrome;
    end
  end

  // Response to the faulting master, one cycle after the abort
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resp_q <= '{valid: 1'b0, code: EFX_RESP_OKAY};
    end else begin
      resp_q.valid <= abort_i.valid & abort_i.sync;
      if (ab_report)               resp_q.code <= EFX_RESP_ABORT;
      else if (abort_i.exclusive)  resp_q.code <= EFX_RESP_EXFAIL;
      else                         resp_q.code <= EFX_RESP_OKAY;
    end
  end

  // ==========================================================
  // Software registers
  // ==========================================================
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gctrl_q <= 3'h0;
      for (int i = 0; i < NUM_CTX; i++) ccfg_q[i] <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == GCTRL_OFS) begin
      gctrl_q <= reg_wdata_i[2:0];
    end else if (reg_wr_i && ctx_hit && ctx_ofs == CCFG_OFS) begin
      ccfg_q[ctx_idx] <= reg_wdata_i[7:0];
    end
  end

  // Command capture; a command to a busy bank simply replaces it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_CTX; i++) begin
        opaddr_q[i] <= RESET_WORD;
        opkind_q[i] <= 2'h0;
      end
    end else if (cmd_wr) begin
      opaddr_q[ctx_idx] <= reg_wdata_i;
      opkind_q[ctx_idx] <= ctx_ofs[3:2];
    end
  end

  // ==========================================================
  // Translation command engine
  // ==========================================================
  logic               rsp_in;
  logic               term_s2;
  logic [NUM_CTX-1:0] start_vec;
  logic [NUM_CTX-1:0] done_vec;
  logic [NUM_CTX-1:0] take_vec;

  // Fault status is not consulted: commands never wait on it
  assign rsp_in    = (state_q == EFX_WAIT) & walk_rsp_i.valid;
  assign term_s2   = ccfg_q[op_s2_ctx][CCFG_TERM_BIT];
  assign start_vec = cmd_wr ? NUM_CTX'(1) << ctx_idx : '0;
  assign done_vec  = (state_q == EFX_DONE) ? NUM_CTX'(1) << sel_q : '0;
  assign take_vec  = (state_q == EFX_ISSUE) ? NUM_CTX'(1) << sel_q : '0;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= EFX_IDLE;
      sel_q   <= '0;
    end else begin
      unique case (state_q)
        EFX_IDLE: begin
          if (|pend_q) begin
            sel_q   <= first_one(pend_q);
            state_q <= EFX_ISSUE;
          end
        end
        EFX_ISSUE: state_q <= EFX_WAIT;
        EFX_WAIT: begin
          // Stall model on stage 2: stay until the walker answers again
          if (rsp_in && !(op_s2_fault && !term_s2)) state_q <= EFX_DONE;
        end
        EFX_DONE: state_q <= EFX_IDLE;
      endcase
    end
  end

  // Progress bit: start wins over the end of an older command
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_q <= '0;
      pend_q   <= '0;
    end else begin
      active_q <= (active_q & ~done_vec) | start_vec;
      pend_q   <= (pend_q & ~take_vec) | start_vec;
    end
  end

  // Result lands in WAIT, progress drops in DONE a cycle later
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_CTX; i++) result_q[i] <= RESET_WORD;
    end else if (rsp_in) begin
      if (walk_rsp_i.ok) begin
        result_q[sel_q] <= {walk_rsp_i.out_addr[31:1], 1'b0};
      end else if (op_s2_fault) begin
        if (term_s2) result_q[sel_q] <= {24'h0, OP_TERMINATED_CODE, 1'b1};
      end else if (walk_rsp_i.ext_abort) begin
        result_q[sel_q] <= {24'h0, OP_EXT_ABORT_CODE, 1'b1};
      end else begin
        result_q[sel_q] <= {24'h0, walk_rsp_i.code, 1'b1};
      end
    end
  end

  // Walk request, one-cycle pulse in ISSUE
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      walk_q <= '0;
    end else begin
      walk_q.valid <= (state_q == EFX_IDLE) & (|pend_q);
      walk_q.ctx   <= 4'(first_one(pend_q));
      walk_q.kind  <= opkind_q[first_one(pend_q)];
      walk_q.addr  <= opaddr_q[first_one(pend_q)];
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    if (reg_addr_i == GCTRL_OFS)        rd_mux = {29'h0, gctrl_q};
    else if (reg_addr_i == GFSR_NS_OFS) rd_mux = gfsr_ns;
    else if (reg_addr_i == GFSR_S_OFS)  rd_mux = gfsr_s;
    else if (reg_addr_i == GFAR_OFS)    rd_mux = gfar_q;
    else if (reg_addr_i == GSYN_OFS)    rd_mux = gsyn_q;
    else if (ctx_hit) begin
      unique case (ctx_ofs)
        RESULT_OFS:   rd_mux = result_q[ctx_idx];
        PROGRESS_OFS: rd_mux = {31'h0, active_q[ctx_idx]};
        CFSR_OFS:     rd_mux = fsr_q[ctx_idx];
        CCFG_OFS:     rd_mux = {24'h0, ccfg_q[ctx_idx]};
        default:      rd_mux = 32'h0;
      endcase
    end
  end

  // Capture store answers through its own read register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q  <= RESET_WORD;
      ram_rd_q <= 1'b0;
      ram_hi_q <= 1'b0;
    end else begin
      rdata_q  <= reg_rd_i ? rd_mux : 32'h0;
      ram_rd_q <= reg_rd_i & far_page & (reg_addr_i[1:0] == 2'h0)
                & (32'(reg_addr_i[7:3] & 5'h03) < NUM_CTX);
      ram_hi_q <= ~reg_addr_i[CTX_STRIDE_LG-3];
    end
  end

  assign reg_rdata_o  = ram_rd_q ? (ram_hi_q ? ram_rd[63:32] : ram_rd[31:0]) : rdata_q;
  assign abort_resp_o = resp_q;
  assign walk_req_o   = walk_q;
endmodule : efx_top

// ==== dv/efx_sva.sv ====
module efx_sva
  import efx_pkg::*;
#(
  parameter int NUM_CTX = 4
) (
  // Clock, reset and register port
  input wire logic          sys_clk_i,
  input wire logic          reset_n_i,
  input wire logic [7:0]    reg_addr_i,
  input wire logic [31:0]   reg_wdata_i,
  input wire logic          reg_wr_i,
  input wire logic          reg_rd_i,
  input wire logic [31:0]   reg_rdata_o,
  // Abort and walker sides
  input wire efx_abort_t    abort_i,
  input wire efx_resp_t     abort_resp_o,
  input wire efx_walk_req_t walk_req_o,
  input wire efx_walk_rsp_t walk_rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // Outstanding command, one at a time as software must keep
  wire logic [7:0] ofs = reg_addr_i - CTX_BASE;
  wire logic       cmd = reg_wr_i && reg_addr_i >= CTX_BASE && ofs[7:5] < NUM_CTX && !ofs[4];
  logic            pend_q;
  logic [2:0]      bank_q;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_q <= 1'b0;
      bank_q <= 3'h0;
    end else if (cmd) begin
      pend_q <= 1'b1;
      bank_q <= ofs[7:5];
    end else if (walk_rsp_i.valid) begin
      pend_q <= 1'b0;
    end
  end
  // ==========================================================
  // Properties
  sequence s_cmd_idle; cmd && !pend_q; endsequence
  sequence s_walk_out;
    walk_req_o.valid && walk_req_o.addr == $past(reg_wdata_i, 2)
      && walk_req_o.kind == $past(reg_addr_i[3:2], 2);
  endsequence
  property p_walk; s_cmd_idle |-> ##2 s_walk_out; endproperty
  property p_req_pulse; walk_req_o.valid |=> !walk_req_o.valid; endproperty
  property p_walk_cause; walk_req_o.valid |-> pend_q; endproperty
  property p_progress;
    reg_rd_i && pend_q && reg_addr_i == CTX_BASE + {bank_q, PROGRESS_OFS} |=> reg_rdata_o[0];
  endproperty
  property p_sync_resp; abort_i.valid && abort_i.sync |=> abort_resp_o.valid; endproperty
  property p_async_quiet; abort_i.valid && !abort_i.sync |=> !abort_resp_o.valid; endproperty
  property p_ex;
    abort_i.valid && abort_i.sync && abort_i.exclusive |=> abort_resp_o.code != EFX_RESP_OKAY;
  endproperty
  property p_nonex;
    abort_i.valid && abort_i.sync && !abort_i.exclusive |=> abort_resp_o.code != EFX_RESP_EXFAIL;
  endproperty
  a_walk: assert property (p_walk)
    else $error("walk request mismatch");
  a_req_pulse: assert property (p_req_pulse)
    else $error("walk request too long");
  a_walk_cause: assert property (p_walk_cause)
    else $error("walk without command");
  a_progress: assert property (p_progress)
    else $error("progress bit low while busy");
  a_sync_resp: assert property (p_sync_resp)
    else $error("no response to sync abort");
  a_async_quiet: assert property (p_async_quiet)
    else $error("response to async abort");
  a_ex: assert property (p_ex)
    else $error("exclusive fault answered okay");
  a_nonex: assert property (p_nonex)
    else $error("exfail on plain access");
endmodule : efx_sva

bind efx_top efx_sva #(.NUM_CTX(NUM_CTX)) u_sva (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .abort_i(abort_i), .abort_resp_o(abort_resp_o),
  .walk_req_o(walk_req_o), .walk_rsp_i(walk_rsp_i));

// ==== dv/efx_walker.sv ====
// ==========================================================
// Table walker stand-in: answers each request lat_i + 1 cycles after taking it
module efx_walker
  import efx_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          reset_n_i,
  input  wire efx_walk_req_t walk_req_i,
  input  wire logic [3:0]    lat_i,
  input  wire efx_walk_rsp_t shape_i,
  output efx_walk_rsp_t      walk_rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       busy_q;
  // Idle payload flips every cycle so stale data is never mistaken
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_q     <= 1'b0;
      cnt_q      <= 4'h0;
      walk_rsp_o <= '0;
    end else begin
      walk_rsp_o       <= ~walk_rsp_o;
      walk_rsp_o.valid <= 1'b0;
      if (walk_req_i.valid) begin
        busy_q <= 1'b1;
        cnt_q  <= lat_i;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q     <= 1'b0;
        walk_rsp_o <= {1'b1, shape_i[41:0]};
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : efx_walker

// ==== dv/tb.sv ====
module tb
  import efx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i;
  logic [7:0]    reg_addr_i;
  logic [31:0]   reg_wdata_i, reg_rdata_o;
  efx_abort_t    abort_i;
  efx_resp_t     abort_resp_o;
  efx_walk_req_t walk_req_o;
  efx_walk_rsp_t walk_rsp_i, shape;
  logic [3:0]    lat;
  int            bad_count, check_count, cyc;
  efx_top #(.NUM_CTX(4)) u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .abort_i(abort_i),
    .abort_resp_o(abort_resp_o), .walk_req_o(walk_req_o), .walk_rsp_i(walk_rsp_i));
  efx_walker u_walk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .walk_req_i(walk_req_o),
    .lat_i(lat), .shape_i(shape), .walk_rsp_o(walk_rsp_i));
  // ==========================================================
  // Clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Bus and compare helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    v = reg_rdata_o;
  endtask : rd
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rdc
  // Flags are sync, bypass, nested, secure, exclusive; er is valid and code
  task ab(input logic [4:0] f, input logic [3:0] c, input logic [3:0] s2,
          input logic [31:0] a, input logic [2:0] er);
    abort_i <= {1'b1, f, c, s2, a, ~a};
    @(posedge sys_clk_i);
    abort_i.valid <= 1'b0;
    @(posedge sys_clk_i);
    chk({29'h0, abort_resp_o}, {29'h0, er});
  endtask : ab
  // Issue a command and poll until it is done
  task cmd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] exp);
    logic [31:0] d;
    int          n;
    n = 0;
    wr(a, v);
    rdc({a[7:5], 5'h14}, 32'h1);
    do rd({a[7:5], 5'h14}, d); while (d[0] && ++n < 40);
    chk(d, 32'h0);
    rdc({a[7:5], 5'h10}, exp);
  endtask : cmd
  // ==========================================================
  // Scenarios
  task t_sync();
    rdc(8'h08, RESET_WORD);
    wr(8'h00, 32'h1);
    wr(8'h5c, 32'h1);
    wr(8'h7c, 32'h1);
    wr(8'h9c, 32'h1);
    ab(5'b10001, 4'h1, 4'h0, 32'h1111_0000, 3'b110);
    ab(5'b10100, 4'h0, 4'h2, 32'h2222_0000, 3'b110);
    wr(8'h00, 32'h0);
    ab(5'b10001, 4'h3, 4'h0, 32'h3333_0000, 3'b101);
    ab(5'b11010, 4'h0, 4'h0, 32'h4444_0000, 3'b100);
    ab(5'b11010, 4'h0, 4'h0, 32'h5555_0000, 3'b100);
    rdc(8'h78, 32'h1);
    rdc(8'hc8, 32'h1111_0000);
    rdc(8'hcc, 32'heeee_ffff);
    rdc(8'h98, 32'h1);
    rdc(8'h58, 32'h0);
    rdc(8'h08, 32'h8000_0001);
    rdc(8'h0c, 32'h4444_0000);
    rdc(8'h04, 32'h0);
    $display("t_sync done");
  endtask : t_sync
  task t_async();
    wr(8'h08, 32'h8000_0001);
    ab(5'b01010, 4'h0, 4'h0, 32'h6666_0000, 3'b000);
    rdc(8'h04, 32'h1);
    rdc(8'h08, 32'h0);
    wr(8'h00, 32'h2);
    ab(5'b01000, 4'h0, 4'h0, 32'h7777_0000, 3'b000);
    rdc(8'h08, 32'h1);
    wr(8'hb8, 32'h1);
    ab(5'b00000, 4'h3, 4'h0, 32'h8888_0000, 3'b000);
    rdc(8'hb8, 32'h1);
    wr(8'h00, 32'h4);
    ab(5'b00000, 4'h2, 4'h0, 32'h9999_0000, 3'b000);
    rdc(8'h04, 32'h8000_0001);
    rdc(8'h0c, 32'h4444_0000);
    $display("t_async done");
  endtask : t_async
  task t_cmds();
    for (int k = 0; k < 4; k++) begin
      shape <= {4'b0100, 7'h0, 32'hab00_0000 | (k << 8)};
      cmd(8'h60 + 8'(4 * k), 32'h1000_0000 + k, 32'hab00_0000 | (k << 8));
    end
    rdc(8'h78, 32'h1);
    shape <= {4'b0010, 7'h0, 32'h0};
    cmd(8'h8c, 32'h2000_0000, {24'h0, OP_EXT_ABORT_CODE, 1'b1});
    shape <= {4'b0000, 7'h05, 32'h0};
    cmd(8'h84, 32'h2100_0000, {24'h0, 7'h05, 1'b1});
    wr(8'h5c, 32'h23);
    wr(8'h9c, 32'h3);
    wr(8'h98, 32'h8000_0001);
    shape <= {4'b0001, 7'h05, 32'h0};
    cmd(8'h40, 32'h3000_0000, {24'h0, OP_TERMINATED_CODE, 1'b1});
    rdc(8'h98, 32'h1);
    wr(8'h9c, 32'h1);
    wr(8'h40, 32'h4000_0000);
    repeat (20) @(posedge sys_clk_i);
    rdc(8'h54, 32'h1);
    rdc(8'h50, {24'h0, OP_TERMINATED_CODE, 1'b1});
    rdc(8'h98, 32'h8000_0001);
    $display("t_cmds done");
  endtask : t_cmds
  task tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    abort_i = '0;
    shape = '0;
    lat = 4'd6;
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_sync();
    t_async();
    t_cmds();
    tally_and_finish();
  end
endmodule : tb
